// ==== core/lpmc_pkg.sv ====
// constants and types shared by the low-power mode controller
package lpmc_pkg;

  // apb geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // printed indices of the status registers reached by external data moves
  localparam logic [APB_AW-1:0] HW_STATUS_IDX = 8'h0f;
  localparam logic [APB_AW-1:0] UART_STATUS_IDX = 8'h0e;

  // byte addresses, four times the index
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_IRQ_ENABLE = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_UART_CTRL2 = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_STATE = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_EVT_STATUS = 8'h10;
  localparam logic [APB_AW-1:0] ADDR_EVT_MASK = 8'h14;
  localparam logic [APB_AW-1:0] ADDR_UART_STATUS = 8'(UART_STATUS_IDX << 2);
  localparam logic [APB_AW-1:0] ADDR_HW_STATUS = 8'(HW_STATUS_IDX << 2);

  // control register fields
  localparam int CTRL_IDLE_BIT = 0;
  localparam int CTRL_PD_BIT = 1;

  // interrupt enable register fields
  localparam int IEN_EX0_BIT = 0;
  localparam int IEN_EX1_BIT = 2;
  localparam int IEN_SER_BIT = 4;
  localparam int IEN_ALL_BIT = 7;
  localparam logic [7:0] IEN_RESET = 8'h00;

  // second uart control register fields
  localparam int UCTL2_IRQ1_WAKE_BIT = 0;
  localparam int UCTL2_RX_WAKE_BIT = 1;
  localparam logic [1:0] UCTL2_RESET = 2'h0;

  // wake cause bits in the hardware and uart status registers
  localparam int HWST_IRQ0_BIT = 0;
  localparam int HWST_IRQ1_BIT = 1;
  localparam int HWST_RX_BIT = 2;
  localparam int UST_RX_WAKE_BIT = 0;

  // event bits, shared by status and mask
  localparam int EVT_IDLE_BIT = 0;
  localparam int EVT_PD_BIT = 1;
  localparam int EVT_WAKE_BIT = 2;
  localparam int EVT_W = 3;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 3'h0;

  // oscillator restart time and its cycle count, rounded up
  localparam int CLK_PERIOD_PS = 8000;
  localparam int OSC_RESTART_NS = 10000;
  localparam int OSC_RESTART_CYC =
    (OSC_RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLY_W = 12;

  typedef enum logic [2:0] {
    LP_RUN,
    LP_IDLE_ARM,
    LP_IDLE,
    LP_PD_ARM,
    LP_PD,
    LP_WAKE
  } lpmc_state_e;

endpackage : lpmc_pkg

// ==== core/lpmc_top.sv ====
// low-power mode controller with apb register access
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps

// What this block does
// RULE_01 - core clock may stop; ram and sfr contents are kept.
// RULE_02 - idle halts instruction execution; peripherals keep running.
// RULE_03 - idle starts only after the requesting instruction retires.
// RULE_04 - processor state, ram and sfrs are frozen during idle.
// RULE_05 - idle ends on enabled interrupt or hardware reset like power-on.
// RULE_06 - power-down stops the oscillator after the requesting instruction.
// RULE_07 - power-down exits on reset, external interrupt or receive activity.
// RULE_08 - reset exit restores sfr reset values; ram keeps its contents.
// RULE_09 - interrupt exit keeps sfr and ram values from before power-down.
// RULE_10 - software enables interrupt-enable bits for each wake source first.
// RULE_11 - status registers report wake cause; a read clears the source.
// RULE_12 - irq1 wake from power-down needs the irq1 wake enable bit.
// RULE_13 - receive wake needs irq1 wake enable and receive wake enable.
// RULE_14 - a delay counter keeps wake requests low while oscillator restarts.
// RULE_15 - after return from interrupt, execution resumes after power-down.
// RULE_16 - oscillator input is divided by two before reaching internal logic.
// RULE_17 - core reset follows the chip-level reset.
// RULE_18 - write one to a request bit starts idle or power-down; wake clears.
module lpmc_top (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [lpmc_pkg::APB_AW-1:0] PADDR_I,
  input wire logic [lpmc_pkg::APB_DW-1:0] PWDATA_I,
  output logic [lpmc_pkg::APB_DW-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // core handshake
  input wire logic CPU_INSN_DONE_I,
  input wire logic CPU_IRQ_PENDING_I,
  // wake pins
  input wire logic EXT_IRQ0_PIN_N_I,
  input wire logic EXT_IRQ1_PIN_N_I,
  input wire logic RXD_I,
  // clocking and retention controls
  output logic OSC_EN_O,
  output logic CPU_CLK_EN_O,
  output logic PERIPH_CLK_EN_O,
  output logic STATE_HOLD_O,
  output logic CORE_RST_O,
  // interrupt requests towards the core
  output logic EXT_IRQ0_REQ_N_O,
  output logic EXT_IRQ1_REQ_N_O,
  output logic IRQ_O
);
  import lpmc_pkg::*;

  lpmc_state_e state_q;
  logic [1:0] irq0_sync_q;
  logic [1:0] irq1_sync_q;
  logic [1:0] rxd_sync_q;
  logic irq0_prev_q;
  logic irq1_prev_q;
  logic rxd_prev_q;
  logic div_q;
  logic [DLY_W-1:0] dly_q;
  logic hold0_q;
  logic hold1_q;
  logic idle_req_q;
  logic pd_req_q;
  logic [7:0] ien_q;
  logic [1:0] uctl2_q;
  logic [2:0] hwst_q;
  logic ust_q;
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] mask_q;
  logic [EVT_W-1:0] evt_set;
  logic fall0;
  logic fall1;
  logic fall_rx;
  logic wake0;
  logic wake1;
  logic wake_rx;
  logic pd_wake;
  logic idle_wake;
  logic wake_done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [APB_DW-1:0] rd_data;

  // returns one when the address maps to a register
  function automatic logic addr_valid(input logic [APB_AW-1:0] a);
    case (a)
      ADDR_CTRL, ADDR_IRQ_ENABLE, ADDR_UART_CTRL2, ADDR_STATE,
      ADDR_EVT_STATUS, ADDR_EVT_MASK, ADDR_UART_STATUS,
      ADDR_HW_STATUS: addr_valid = 1'b1;
      default: addr_valid = 1'b0;
    endcase
  endfunction : addr_valid

  // pins are asynchronous, two stages before any use
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      irq0_sync_q <= 2'h3;
      irq1_sync_q <= 2'h3;
      rxd_sync_q <= 2'h3;
      irq0_prev_q <= 1'b1;
      irq1_prev_q <= 1'b1;
      rxd_prev_q <= 1'b1;
    end else begin
      irq0_sync_q <= {irq0_sync_q[0], EXT_IRQ0_PIN_N_I};
      irq1_sync_q <= {irq1_sync_q[0], EXT_IRQ1_PIN_N_I};
      rxd_sync_q <= {rxd_sync_q[0], RXD_I};
      irq0_prev_q <= irq0_sync_q[1];
      irq1_prev_q <= irq1_sync_q[1];
      rxd_prev_q <= rxd_sync_q[1];
    end
  end

  // a single falling edge is enough to wake the device
  assign fall0 = irq0_prev_q & ~irq0_sync_q[1]; // [RULE_14]
  assign fall1 = irq1_prev_q & ~irq1_sync_q[1]; // [RULE_14]
  assign fall_rx = rxd_prev_q & ~rxd_sync_q[1]; // [RULE_14]

  // wake qualification; software must set the enable bits beforehand
  assign wake0 = fall0 & ien_q[IEN_ALL_BIT] & ien_q[IEN_EX0_BIT]; // [RULE_10]
  assign wake1 = fall1 & ien_q[IEN_ALL_BIT] & ien_q[IEN_EX1_BIT]
    & uctl2_q[UCTL2_IRQ1_WAKE_BIT]; // [RULE_12]
  assign wake_rx = fall_rx & ien_q[IEN_ALL_BIT] & ien_q[IEN_EX1_BIT]
    & uctl2_q[UCTL2_IRQ1_WAKE_BIT] & uctl2_q[UCTL2_RX_WAKE_BIT]; // [RULE_13]
  assign pd_wake = wake0 | wake1 | wake_rx; // [RULE_07]
  // any interrupt the core accepts ends idle
  assign idle_wake = CPU_IRQ_PENDING_I; // [RULE_05]
  assign wake_done = (state_q == LP_WAKE) && (dly_q == '0);

  // mode sequencer
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_q <= LP_RUN; // [RULE_05] [RULE_08]
    end else begin
      case (state_q)
        LP_RUN: begin
          if (pd_req_q) begin
            state_q <= LP_PD_ARM;
          end else if (idle_req_q) begin
            state_q <= LP_IDLE_ARM;
          end
        end
        // the requesting instruction retires before the halt
        LP_IDLE_ARM: begin
          if (CPU_INSN_DONE_I) begin
            state_q <= LP_IDLE; // [RULE_03]
          end
        end
        LP_IDLE: begin
          if (idle_wake) begin
            state_q <= LP_RUN; // [RULE_05]
          end
        end
        LP_PD_ARM: begin
          if (CPU_INSN_DONE_I) begin
            state_q <= LP_PD; // [RULE_06]
          end
        end
        LP_PD: begin
          if (pd_wake) begin
            state_q <= LP_WAKE; // [RULE_07]
          end
        end
        LP_WAKE: begin
          if (dly_q == '0) begin
            state_q <= LP_RUN; // [RULE_09] [RULE_15]
          end
        end
        default: state_q <= LP_RUN;
      endcase
    end
  end

  // restart delay; requests stay low until the oscillator is stable
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      dly_q <= '0;
      hold0_q <= 1'b0;
      hold1_q <= 1'b0;
    end else if (state_q == LP_PD && pd_wake) begin
      dly_q <= DLY_W'(OSC_RESTART_CYC - 1); // [RULE_14]
      hold0_q <= wake0;
      hold1_q <= wake1 | wake_rx;
    end else if (state_q == LP_WAKE && dly_q != '0) begin
      dly_q <= dly_q - DLY_W'(1);
    end else if (state_q == LP_RUN && CPU_IRQ_PENDING_I) begin
      // released once the core has accepted the request
      hold0_q <= 1'b0;
      hold1_q <= 1'b0;
    end
  end

  // interrupt request lines: pin level, or forced low by the hold
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      EXT_IRQ0_REQ_N_O <= 1'b1;
      EXT_IRQ1_REQ_N_O <= 1'b1;
    end else begin
      EXT_IRQ0_REQ_N_O <= irq0_sync_q[1] & ~hold0_q; // [RULE_14]
      EXT_IRQ1_REQ_N_O <= irq1_sync_q[1] & ~hold1_q; // [RULE_14]
    end
  end

  // divide by two: internal logic sees half the input rate
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      div_q <= 1'b0;
    end else if (state_q == LP_PD || state_q == LP_WAKE) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q; // [RULE_16]
    end
  end

  // clock gating and state freezing
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      OSC_EN_O <= 1'b1;
      CPU_CLK_EN_O <= 1'b0;
      PERIPH_CLK_EN_O <= 1'b0;
      STATE_HOLD_O <= 1'b0;
    end else begin
      // oscillator off only in power-down proper
      OSC_EN_O <= (state_q != LP_PD); // [RULE_06]
      CPU_CLK_EN_O <= ~div_q && (state_q == LP_RUN ||
        state_q == LP_IDLE_ARM || state_q == LP_PD_ARM); // [RULE_02]
      PERIPH_CLK_EN_O <= ~div_q && state_q != LP_PD &&
        state_q != LP_WAKE; // [RULE_02]
      // static core: a stopped clock keeps ram and sfr contents
      STATE_HOLD_O <= (state_q == LP_IDLE || state_q == LP_PD ||
        state_q == LP_WAKE); // [RULE_01] [RULE_04] [RULE_09]
    end
  end

  // core reset tracks chip reset; ram has no reset, only sfrs do
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CORE_RST_O <= 1'b1; // [RULE_17] [RULE_08]
    end else begin
      CORE_RST_O <= 1'b0;
    end
  end

  // apb decode
  assign addr_ok = addr_valid(PADDR_I);
  assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & addr_ok;
  assign rd_en = PSEL_I & PENABLE_I & PREADY_O & ~PWRITE_I & addr_ok;

  // request bits: write one sets, wake clears
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      idle_req_q <= 1'b0;
      pd_req_q <= 1'b0;
    end else begin
      if (wr_en && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_IDLE_BIT]) begin
        idle_req_q <= 1'b1; // [RULE_18]
      end else if (state_q == LP_IDLE && idle_wake) begin
        idle_req_q <= 1'b0; // [RULE_18]
      end
      if (wr_en && PADDR_I == ADDR_CTRL && PWDATA_I[CTRL_PD_BIT]) begin
        pd_req_q <= 1'b1; // [RULE_18]
      end else if (wake_done) begin
        pd_req_q <= 1'b0; // [RULE_18]
      end
    end
  end

  // configuration registers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ien_q <= IEN_RESET;
      uctl2_q <= UCTL2_RESET;
      mask_q <= EVT_MASK_RESET;
    end else if (wr_en) begin
      case (PADDR_I)
        ADDR_IRQ_ENABLE: ien_q <= PWDATA_I[7:0];
        ADDR_UART_CTRL2: uctl2_q <= PWDATA_I[1:0];
        ADDR_EVT_MASK: mask_q <= PWDATA_I[EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // wake cause, cleared by reading; a new cause in the same cycle wins
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      hwst_q <= '0;
      ust_q <= 1'b0;
    end else begin
      if (state_q == LP_PD) begin
        hwst_q[HWST_IRQ0_BIT] <= wake0 |
          (hwst_q[HWST_IRQ0_BIT] & ~(rd_en && PADDR_I == ADDR_HW_STATUS));
        hwst_q[HWST_IRQ1_BIT] <= wake1 |
          (hwst_q[HWST_IRQ1_BIT] & ~(rd_en && PADDR_I == ADDR_HW_STATUS));
        hwst_q[HWST_RX_BIT] <= wake_rx |
          (hwst_q[HWST_RX_BIT] & ~(rd_en && PADDR_I == ADDR_HW_STATUS));
        ust_q <= wake_rx |
          (ust_q & ~(rd_en && PADDR_I == ADDR_UART_STATUS));
      end else begin
        if (rd_en && PADDR_I == ADDR_HW_STATUS) begin
          hwst_q <= '0; // [RULE_11]
        end
        if (rd_en && PADDR_I == ADDR_UART_STATUS) begin
          ust_q <= 1'b0; // [RULE_11]
        end
      end
    end
  end

  // event status: set wins over write-one-clear
  assign evt_set[EVT_IDLE_BIT] = (state_q == LP_IDLE_ARM) & CPU_INSN_DONE_I;
  assign evt_set[EVT_PD_BIT] = (state_q == LP_PD_ARM) & CPU_INSN_DONE_I;
  assign evt_set[EVT_WAKE_BIT] = wake_done;

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      evt_q <= '0;
    end else if (wr_en && PADDR_I == ADDR_EVT_STATUS) begin
      evt_q <= evt_set | (evt_q & ~PWDATA_I[EVT_W-1:0]);
    end else begin
      evt_q <= evt_set | evt_q;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(evt_q & mask_q);
    end
  end

  // read mux
  always_comb begin
    rd_data = '0;
    case (PADDR_I)
      ADDR_CTRL: rd_data = {30'h0, pd_req_q, idle_req_q};
      ADDR_IRQ_ENABLE: rd_data = {24'h0, ien_q};
      ADDR_UART_CTRL2: rd_data = {30'h0, uctl2_q};
      ADDR_STATE: rd_data = {29'h0, state_q};
      ADDR_EVT_STATUS: rd_data = {29'h0, evt_q};
      ADDR_EVT_MASK: rd_data = {29'h0, mask_q};
      ADDR_UART_STATUS: rd_data = {31'h0, ust_q}; // [RULE_11]
      ADDR_HW_STATUS: rd_data = {29'h0, hwst_q}; // [RULE_11]
      default: rd_data = '0;
    endcase
  end

  // no wait state: ready in the first access cycle
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= '0;
    end else if (PSEL_I && !PENABLE_I && !PREADY_O) begin
      PREADY_O <= 1'b1;
      PSLVERR_O <= ~addr_ok;
      PRDATA_O <= PWRITE_I ? '0 : rd_data;
    end else begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

endmodule : lpmc_top

// ==== test/lpmc_props.sv ====
// port assertions for the low-power mode controller
`timescale 1ns/10ps
module lpmc_chk (
  // clock and reset
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  // apb
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  // wake pins
  input wire logic EXT_IRQ0_PIN_N_I,
  input wire logic EXT_IRQ1_PIN_N_I,
  input wire logic RXD_I,
  // controls
  input wire logic OSC_EN_O,
  input wire logic CPU_CLK_EN_O,
  input wire logic PERIPH_CLK_EN_O,
  input wire logic STATE_HOLD_O,
  input wire logic CORE_RST_O,
  input wire logic EXT_IRQ0_REQ_N_O,
  input wire logic EXT_IRQ1_REQ_N_O
);
  import lpmc_pkg::*;
  logic osc_prev_q;
  logic in_wake_q;
  logic [10:0] wake_cnt_q;
  // restart window counted here: a delay range that long would crawl
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      osc_prev_q <= 1'b1;
      in_wake_q <= 1'b0;
      wake_cnt_q <= 11'h0;
    end else begin
      osc_prev_q <= OSC_EN_O;
      if (OSC_EN_O && !osc_prev_q) begin
        in_wake_q <= 1'b1;
        wake_cnt_q <= 11'h1;
      end else if (in_wake_q && !STATE_HOLD_O) begin
        in_wake_q <= 1'b0;
      end else if (in_wake_q) begin
        wake_cnt_q <= wake_cnt_q + 11'h1;
      end
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  apb_answer_a: assert property (
    PSEL_I && !PENABLE_I |=> PREADY_O) else $error("no ready after setup");
  half_rate_a: assert property (
    CPU_CLK_EN_O |=> !CPU_CLK_EN_O) else $error("core enable not halved");
  cpu_freeze_a: assert property (
    CPU_CLK_EN_O |-> !STATE_HOLD_O) else $error("core clocked while held");
  osc_stop_a: assert property (
    !OSC_EN_O |-> STATE_HOLD_O && !CPU_CLK_EN_O && !PERIPH_CLK_EN_O)
    else $error("clocks run with oscillator off");
  pd_stay_a: assert property (
    (!OSC_EN_O && EXT_IRQ0_PIN_N_I && EXT_IRQ1_PIN_N_I && RXD_I)[*8]
    |=> !OSC_EN_O) else $error("woke without a pin edge");
  // unqualified pin pulses in power-down may reach the lines; only the
  // restart window must keep a request low
  req_hold_a: assert property (
    in_wake_q |-> !(EXT_IRQ0_REQ_N_O && EXT_IRQ1_REQ_N_O))
    else $error("wake request dropped early");
  wake_len_a: assert property (
    $fell(STATE_HOLD_O) && in_wake_q |-> wake_cnt_q == 11'(OSC_RESTART_CYC))
    else $error("oscillator restart wait wrong");
  wake_max_a: assert property (
    in_wake_q |-> wake_cnt_q <= 11'(OSC_RESTART_CYC))
    else $error("oscillator restart wait too long");
  rst_release_a: assert property (
    $fell(RST_I) |-> CORE_RST_O && OSC_EN_O && !STATE_HOLD_O)
    else $error("reset values wrong");
  core_run_a: assert property (
    !$past(RST_I) |-> !CORE_RST_O) else $error("core reset stuck");
  cover property (!OSC_EN_O);
  cover property ($fell(STATE_HOLD_O));
  cover property (STATE_HOLD_O && OSC_EN_O && PERIPH_CLK_EN_O);
endmodule : lpmc_chk

bind lpmc_top lpmc_chk i_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
  .EXT_IRQ0_PIN_N_I(EXT_IRQ0_PIN_N_I), .EXT_IRQ1_PIN_N_I(EXT_IRQ1_PIN_N_I),
  .RXD_I(RXD_I), .OSC_EN_O(OSC_EN_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
  .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .STATE_HOLD_O(STATE_HOLD_O),
  .CORE_RST_O(CORE_RST_O), .EXT_IRQ0_REQ_N_O(EXT_IRQ0_REQ_N_O),
  .EXT_IRQ1_REQ_N_O(EXT_IRQ1_REQ_N_O));

// ==== test/lpmc_core_model.sv ====
// behavioural core: retires instructions, takes interrupts
`timescale 1ns/10ps
module lpmc_core_model #(
  parameter int DONE_GAP = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from the controller
  input wire logic cpu_clk_en_i,
  input wire logic hold_i,
  input wire logic req0_n_i,
  input wire logic req1_n_i,
  // from the bench
  input wire logic irq_cmd_i,
  // to the controller
  output logic insn_done_o,
  output logic irq_pend_o
);
  logic [3:0] gap_q;
  // retire only on enabled core cycles, so a held core never retires
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= 4'h0;
      insn_done_o <= 1'b0;
    end else begin
      insn_done_o <= 1'b0;
      if (cpu_clk_en_i && !hold_i) begin
        gap_q <= gap_q + 4'h1;
        if (gap_q == 4'(DONE_GAP)) begin
          gap_q <= 4'h0;
          insn_done_o <= 1'b1;
        end
      end
    end
  end
  // wake requests are taken only once the core runs again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_pend_o <= 1'b0;
    end else begin
      irq_pend_o <= irq_cmd_i |
        (!hold_i & !(req0_n_i & req1_n_i));
    end
  end
endmodule : lpmc_core_model

// ==== test/lpmc_tb.sv ====
// self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module testbench;
  import lpmc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0, prdata;
  logic [2:0] pins = 3'b111;
  logic irq_cmd = 1'b0, pready, pslverr, done, pend, osc, cpu_en, per_en;
  logic hold, crst, r0n, r1n, irq;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  lpmc_top i_dut (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CPU_INSN_DONE_I(done), .CPU_IRQ_PENDING_I(pend),
    .EXT_IRQ0_PIN_N_I(pins[0]), .EXT_IRQ1_PIN_N_I(pins[1]), .RXD_I(pins[2]),
    .OSC_EN_O(osc), .CPU_CLK_EN_O(cpu_en), .PERIPH_CLK_EN_O(per_en),
    .STATE_HOLD_O(hold), .CORE_RST_O(crst), .EXT_IRQ0_REQ_N_O(r0n),
    .EXT_IRQ1_REQ_N_O(r1n), .IRQ_O(irq));
  lpmc_core_model #(.DONE_GAP(2)) i_core (.clk_i(clk), .rst_i(rst),
    .cpu_clk_en_i(cpu_en), .hold_i(hold), .req0_n_i(r0n), .req1_n_i(r1n),
    .irq_cmd_i(irq_cmd), .insn_done_o(done), .irq_pend_o(pend));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask : rd
  task automatic wait_hold(input logic v);
    for (int i = 0; i < 2000 && hold !== v; i++) @(posedge clk);
    chk(32'(hold), 32'(v));
  endtask : wait_hold
  // a single short low pulse must be enough to wake
  task automatic pulse(input int k);
    @(posedge clk);
    pins[k] <= 1'b0;
    repeat (3) @(posedge clk);
    pins <= 3'b111;
  endtask : pulse
  task automatic sleep();
    wr(ADDR_CTRL, 32'h2);
    for (int i = 0; i < 100 && osc !== 1'b0; i++) @(posedge clk);
    chk(32'(osc), 32'h0);
  endtask : sleep
  task automatic t_reset();
    chk(32'({crst, osc, hold, irq}), 32'h4);
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_IRQ_ENABLE, 32'h0, 1'b0);
    rd(ADDR_UART_CTRL2, 32'h0, 1'b0);
    rd(ADDR_STATE, 32'(LP_RUN), 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_idle();
    logic a;
    wr(ADDR_EVT_MASK, 32'h1);
    wr(ADDR_CTRL, 32'h1);
    wait_hold(1'b1);
    a = per_en;
    @(posedge clk);
    chk(32'({osc, cpu_en, a ^ per_en}), 32'h5);
    rd(ADDR_STATE, 32'(LP_IDLE), 1'b0);
    rd(ADDR_EVT_STATUS, 32'h1, 1'b0);
    chk(32'(irq), 32'h1);
    wr(ADDR_EVT_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    irq_cmd <= 1'b1;
    wait_hold(1'b0);
    irq_cmd <= 1'b0;
    rd(ADDR_CTRL, 32'h0, 1'b0);
    $display("idle test done");
  endtask : t_idle
  task automatic t_pd_irq0();
    wr(ADDR_IRQ_ENABLE, 32'h81);
    sleep();
    rd(ADDR_STATE, 32'(LP_PD), 1'b0);
    pulse(0);
    wait_hold(1'b0);
    rd(ADDR_HW_STATUS, 32'h1, 1'b0);
    rd(ADDR_HW_STATUS, 32'h0, 1'b0);
    rd(ADDR_IRQ_ENABLE, 32'h81, 1'b0);
    rd(ADDR_CTRL, 32'h0, 1'b0);
    rd(ADDR_EVT_STATUS, 32'h6, 1'b0);
    wr(ADDR_EVT_STATUS, 32'h6);
    $display("power-down irq0 test done");
  endtask : t_pd_irq0
  task automatic t_pd_irq1();
    wr(ADDR_IRQ_ENABLE, 32'h84);
    sleep();
    pulse(1);
    repeat (20) @(posedge clk);
    chk(32'(osc), 32'h0);
    wr(ADDR_UART_CTRL2, 32'h1);
    pulse(1);
    wait_hold(1'b0);
    rd(ADDR_HW_STATUS, 32'h2, 1'b0);
    $display("power-down irq1 test done");
  endtask : t_pd_irq1
  task automatic t_pd_rx();
    sleep();
    pulse(2);
    repeat (20) @(posedge clk);
    chk(32'(osc), 32'h0);
    wr(ADDR_UART_CTRL2, 32'h3);
    pulse(2);
    wait_hold(1'b0);
    rd(ADDR_HW_STATUS, 32'h4, 1'b0);
    rd(ADDR_UART_STATUS, 32'h1, 1'b0);
    rd(ADDR_UART_STATUS, 32'h0, 1'b0);
    $display("power-down receive test done");
  endtask : t_pd_rx
  task automatic t_pd_reset();
    sleep();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(32'({crst, osc, hold}), 32'h2);
    rd(ADDR_IRQ_ENABLE, 32'h0, 1'b0);
    rd(ADDR_UART_CTRL2, 32'h0, 1'b0);
    rd(ADDR_STATE, 32'(LP_RUN), 1'b0);
    $display("power-down reset test done");
  endtask : t_pd_reset
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_idle();
    t_pd_irq0();
    t_pd_irq1();
    t_pd_rx();
    t_pd_reset();
    results();
  end
endmodule : testbench
